// file: design/gjpm_regs.svh
// Register offsets, field positions and timing counts of the pin mux block.
`ifndef GJPM_REGS_SVH
`define GJPM_REGS_SVH
`define GJPM_PORT_A_CONTROL            16'h6f80
`define GJPM_PORT_A_QUALIFIER_SELECT_LOW  16'h6f82
`define GJPM_PORT_A_QUALIFIER_SELECT_HIGH 16'h6f84
`define GJPM_PORT_A_FUNCTION_SELECT_LOW   16'h6f86
`define GJPM_PORT_A_FUNCTION_SELECT_HIGH  16'h6f88
`define GJPM_PORT_A_DIRECTION          16'h6f8a
`define GJPM_PORT_A_PULLUP_DISABLE     16'h6f8c
`define GJPM_PORT_B_CONTROL            16'h6f90
`define GJPM_PORT_B_QUALIFIER_SELECT   16'h6f92
`define GJPM_PORT_B_FUNCTION_SELECT    16'h6f96
`define GJPM_PORT_B_DIRECTION          16'h6f9a
`define GJPM_PORT_B_PULLUP_DISABLE     16'h6f9c
`define GJPM_ANALOG_GROUP_FUNCTION_SELECT 16'h6fb6
`define GJPM_ANALOG_GROUP_DIRECTION    16'h6fba
`define GJPM_PORT_A_VALUE              16'h6fc0
`define GJPM_PORT_A_BIT_SET            16'h6fc2
`define GJPM_PORT_A_BIT_CLEAR          16'h6fc4
`define GJPM_PORT_A_BIT_INVERT         16'h6fc6
`define GJPM_PORT_B_VALUE              16'h6fc8
`define GJPM_PORT_B_BIT_SET            16'h6fca
`define GJPM_PORT_B_BIT_CLEAR          16'h6fcc
`define GJPM_PORT_B_BIT_INVERT         16'h6fce
`define GJPM_ANALOG_GROUP_VALUE        16'h6fd8
`define GJPM_ANALOG_GROUP_BIT_SET      16'h6fda
`define GJPM_ANALOG_GROUP_BIT_CLEAR    16'h6fdc
`define GJPM_ANALOG_GROUP_BIT_INVERT   16'h6fde
`define GJPM_EXT_IRQ_ONE_PIN_SELECT    16'h6fe0
`define GJPM_EXT_IRQ_TWO_PIN_SELECT    16'h6fe1
`define GJPM_EXT_IRQ_THREE_PIN_SELECT  16'h6fe2
`define GJPM_WAKE_PIN_SELECT           16'h6fe8
`define GJPM_PORT_A_PINS               32
`define GJPM_PORT_B_PINS               13
`define GJPM_ANALOG_PINS               16
`define GJPM_PIN_COUNT                 45
`define GJPM_FUNC_GPIO                 2'h0
`define GJPM_MUX_DELAY_CYCLES          2
`define GJPM_PORT_B_TDI                3
`define GJPM_PORT_B_TMS                4
`define GJPM_PORT_B_TDO                5
`define GJPM_PORT_B_TCK                6
`endif

// file: design/gjpm_pkg.sv
// Types shared by the pin mux block.
package gjpm_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } gjpm_bus_s;
  typedef struct packed {
    logic [44:0] out;
    logic [44:0] oe;
  } gjpm_pins_s;
endpackage

// file: design/gjpm_pin_mux.sv
// Pin multiplexer with GPIO registers and debug port sharing.
`timescale 1ns/100ps
`default_nettype none
`include "gjpm_regs.svh"
// What this block does
// (RQ1) Pin routes three peripherals or software GPIO.
// (RQ2) Forty-five individually configurable digital pins.
// (RQ3) Registers accept 32-bit and 16-bit accesses, except that a 16-bit read of the wake mask upper half returns its low half.
// (RQ4) Port A, port B, analog group registers.
// (RQ5) Port A function select split low/high.
// (RQ6) Per-pin qualifier select, port A split.
// (RQ7) Direction bit per pin per port.
// (RQ8) Pull-up disable bit per pin.
// (RQ9) Data, set, clear, toggle registers per port.
// (RQ10) Control registers writable only when protection open.
// (RQ11) Three interrupt pin selects from port A.
// (RQ12) Wake-up pin mask for port A.
// (RQ13) Mux and qualifier writes act two cycles later.
// (RQ14) Test reset picks debug or GPIO.
// (RQ15) Debug active hides GPIO on test pins.
// (RQ16) Five test pins, four shared with GPIO.
// (RQ17) System switches clock away during debug.
// (RQ18) Two-bit select, zero means GPIO.
// (RQ19) Software avoids reserved select codes.
// (RQ20) Write one sets, clears or inverts latch.
// (RQ21) Protected writes ignored while protection closed.
module gjpm_pin_mux
  import gjpm_pkg::*;
(
  // Clock and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // Register bus.
  input  wire gjpm_bus_s   BUS,
  input  wire logic        PROTECTED_WRITE_ENABLE,
  output logic [31:0]      RDATA,
  // Peripheral choices, three per pin.
  input  wire logic [44:0] PERIPH_OUT [3],
  input  wire logic [44:0] PERIPH_OE [3],
  output logic [44:0]      PERIPH_IN,
  // Pins.
  input  wire logic [44:0] PIN_IN,
  output gjpm_pins_s       PIN,
  output logic [44:0]      PULLUP_ENABLE,
  output logic [47:0]      INPUT_QUALIFIER_SELECT,
  output logic [31:0]      QUALIFIER_CONTROL_A,
  output logic [31:0]      QUALIFIER_CONTROL_B,
  // Analog group.
  input  wire logic [15:0] ANALOG_IN,
  output logic [15:0]      ANALOG_OUT,
  output logic [15:0]      ANALOG_OE,
  output logic [15:0]      ANALOG_PIN_FUNCTION_SELECT,
  // Debug port sharing.
  input  wire logic        TEST_RESET,
  input  wire logic        TEST_DATA_OUT,
  output logic [3:0]       TEST_PINS_IN,
  // Interrupt and wake selects.
  output logic             EXTERNAL_INTERRUPT_ONE,
  output logic             EXTERNAL_INTERRUPT_TWO,
  output logic             EXTERNAL_INTERRUPT_THREE,
  output logic [31:0]      LOW_POWER_STATE_WAKE
);
  logic [31:0] ctrl_a, ctrl_b, qsel_a_lo, qsel_a_hi, qsel_b, fsel_a_lo, fsel_a_hi, fsel_b;
  logic [31:0] dir_a, pud_a, lat_a, fsel_ai, wake;
  logic [12:0] dir_b, pud_b, lat_b;
  logic [15:0] dir_ai, lat_ai, xsel1, xsel2, xsel3;
  logic [31:0] q_fsel_a_lo [2], q_fsel_a_hi [2], q_fsel_b [2], q_fsel_ai [2];
  logic [31:0] q_qa_lo [2], q_qa_hi [2], q_qb [2];
  logic [44:0] sync1, sync2;
  logic [1:0]  tr_sync;
  logic [15:0] ai_sync1, ai_sync2;
  logic [31:0] wmask, rd_mux;
  logic        prot_wr;
  logic [89:0] fsel_all;
  logic        debug_mode;

  // A 16-bit access touches one half word; an odd address is the upper half.
  always_comb begin
    wmask = 32'hffffffff; // RQ3
    if (!BUS.wide) begin
      wmask = BUS.addr[0] ? 32'hffff0000 : 32'h0000ffff;
    end
  end

  function automatic logic hit(input logic [15:0] a);
    hit = BUS.wr && ((BUS.addr & 16'hfffe) == a);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] d;
    d = BUS.addr[0] && !BUS.wide ? {BUS.wdata[15:0], 16'h0000} : BUS.wdata;
    merge = (old & ~wmask) | (d & wmask);
  endfunction

  function automatic logic [31:0] wbits();
    wbits = merge(32'h00000000);
  endfunction

  assign prot_wr = PROTECTED_WRITE_ENABLE; // RQ10

  // Protected control registers.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_a <= 32'h0;
      ctrl_b <= 32'h0;
      qsel_a_lo <= 32'h0;
      qsel_a_hi <= 32'h0;
      qsel_b <= 32'h0;
      fsel_a_lo <= 32'h0;
      fsel_a_hi <= 32'h0;
      fsel_b <= 32'h0;
      fsel_ai <= 32'h0;
      dir_a <= 32'h0;
      dir_b <= 13'h0;
      dir_ai <= 16'h0;
      pud_a <= 32'h0;
      pud_b <= 13'h0;
      xsel1 <= 16'h0;
      xsel2 <= 16'h0;
      xsel3 <= 16'h0;
      wake <= 32'h0;
    end else if (prot_wr) begin // RQ21
      if (hit(`GJPM_PORT_A_CONTROL)) ctrl_a <= merge(ctrl_a);
      if (hit(`GJPM_PORT_B_CONTROL)) ctrl_b <= merge(ctrl_b);
      if (hit(`GJPM_PORT_A_QUALIFIER_SELECT_LOW)) qsel_a_lo <= merge(qsel_a_lo); // RQ6
      if (hit(`GJPM_PORT_A_QUALIFIER_SELECT_HIGH)) qsel_a_hi <= merge(qsel_a_hi); // RQ6
      if (hit(`GJPM_PORT_B_QUALIFIER_SELECT)) qsel_b <= merge(qsel_b) & 32'h03ffffff;
      if (hit(`GJPM_PORT_A_FUNCTION_SELECT_LOW)) fsel_a_lo <= merge(fsel_a_lo); // RQ5
      if (hit(`GJPM_PORT_A_FUNCTION_SELECT_HIGH)) fsel_a_hi <= merge(fsel_a_hi); // RQ5
      if (hit(`GJPM_PORT_B_FUNCTION_SELECT)) fsel_b <= merge(fsel_b) & 32'h03ffffff;
      if (hit(`GJPM_ANALOG_GROUP_FUNCTION_SELECT)) fsel_ai <= merge(fsel_ai);
      if (hit(`GJPM_PORT_A_DIRECTION)) dir_a <= merge(dir_a); // RQ7
      if (hit(`GJPM_PORT_B_DIRECTION)) dir_b <= 13'(merge({19'h0, dir_b})); // RQ7
      if (hit(`GJPM_ANALOG_GROUP_DIRECTION)) dir_ai <= 16'(merge({16'h0, dir_ai})); // RQ7
      if (hit(`GJPM_PORT_A_PULLUP_DISABLE)) pud_a <= merge(pud_a); // RQ8
      if (hit(`GJPM_PORT_B_PULLUP_DISABLE)) pud_b <= 13'(merge({19'h0, pud_b})); // RQ8
      if (BUS.wr && BUS.addr == `GJPM_EXT_IRQ_ONE_PIN_SELECT) xsel1 <= BUS.wdata[15:0]; // RQ11
      if (BUS.wr && BUS.addr == `GJPM_EXT_IRQ_TWO_PIN_SELECT) xsel2 <= BUS.wdata[15:0]; // RQ11
      if (BUS.wr && BUS.addr == `GJPM_EXT_IRQ_THREE_PIN_SELECT) xsel3 <= BUS.wdata[15:0]; // RQ11
      if (hit(`GJPM_WAKE_PIN_SELECT)) wake <= merge(wake); // RQ12
    end
  end

  // Output latches with set, clear and toggle strobes; never protected.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lat_a <= 32'h0;
      lat_b <= 13'h0;
      lat_ai <= 16'h0;
    end else begin
      if (hit(`GJPM_PORT_A_VALUE)) lat_a <= merge(lat_a); // RQ9
      else if (hit(`GJPM_PORT_A_BIT_SET)) lat_a <= lat_a | wbits(); // RQ20
      else if (hit(`GJPM_PORT_A_BIT_CLEAR)) lat_a <= lat_a & ~wbits(); // RQ20
      else if (hit(`GJPM_PORT_A_BIT_INVERT)) lat_a <= lat_a ^ wbits(); // RQ20
      if (hit(`GJPM_PORT_B_VALUE)) lat_b <= 13'(merge({19'h0, lat_b})); // RQ9
      else if (hit(`GJPM_PORT_B_BIT_SET)) lat_b <= lat_b | 13'(wbits()); // RQ20
      else if (hit(`GJPM_PORT_B_BIT_CLEAR)) lat_b <= lat_b & ~13'(wbits()); // RQ20
      else if (hit(`GJPM_PORT_B_BIT_INVERT)) lat_b <= lat_b ^ 13'(wbits()); // RQ20
      if (hit(`GJPM_ANALOG_GROUP_VALUE)) lat_ai <= 16'(merge({16'h0, lat_ai})); // RQ9
      else if (hit(`GJPM_ANALOG_GROUP_BIT_SET)) lat_ai <= lat_ai | 16'(wbits()); // RQ20
      else if (hit(`GJPM_ANALOG_GROUP_BIT_CLEAR)) lat_ai <= lat_ai & ~16'(wbits()); // RQ20
      else if (hit(`GJPM_ANALOG_GROUP_BIT_INVERT)) lat_ai <= lat_ai ^ 16'(wbits()); // RQ20
    end
  end

  // Two-stage delay line so mux and qualifier writes act two cycles later.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < `GJPM_MUX_DELAY_CYCLES; i++) begin
        q_fsel_a_lo[i] <= 32'h0; q_fsel_a_hi[i] <= 32'h0; q_fsel_b[i] <= 32'h0; q_fsel_ai[i] <= 32'h0;
        q_qa_lo[i] <= 32'h0; q_qa_hi[i] <= 32'h0; q_qb[i] <= 32'h0;
      end
    end else begin
      q_fsel_a_lo[0] <= fsel_a_lo; q_fsel_a_hi[0] <= fsel_a_hi; // RQ13
      q_fsel_b[0] <= fsel_b; q_fsel_ai[0] <= fsel_ai; // RQ13
      q_qa_lo[0] <= qsel_a_lo; q_qa_hi[0] <= qsel_a_hi; q_qb[0] <= qsel_b; // RQ13
      q_fsel_a_lo[1] <= q_fsel_a_lo[0]; q_fsel_a_hi[1] <= q_fsel_a_hi[0];
      q_fsel_b[1] <= q_fsel_b[0]; q_fsel_ai[1] <= q_fsel_ai[0];
      q_qa_lo[1] <= q_qa_lo[0]; q_qa_hi[1] <= q_qa_hi[0]; q_qb[1] <= q_qb[0];
    end
  end

  // Pin and test reset synchronisers.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sync1 <= 45'h0;
      sync2 <= 45'h0;
      tr_sync <= 2'h0;
      ai_sync1 <= 16'h0;
      ai_sync2 <= 16'h0;
    end else begin
      sync1 <= PIN_IN;
      sync2 <= sync1;
      tr_sync <= {tr_sync[0], TEST_RESET};
      ai_sync1 <= ANALOG_IN;
      ai_sync2 <= ai_sync1;
    end
  end

  assign debug_mode = tr_sync[1]; // RQ14
  // The effective select is the delayed one, from the second stage only.
  assign fsel_all = {q_fsel_b[1][25:0], q_fsel_a_hi[1], q_fsel_a_lo[1]}; // RQ2

  // Per-pin routing; select zero is the latch and direction, one to three pick a peripheral.
  always_comb begin
    logic [1:0] s;
    logic [44:0] lat_all, dir_all;
    s = 2'h0;
    lat_all = {lat_b, lat_a};
    dir_all = {dir_b, dir_a};
    PIN = '0;
    for (int p = 0; p < `GJPM_PIN_COUNT; p++) begin
      s = fsel_all[2*p +: 2];
      if (s == `GJPM_FUNC_GPIO) begin // RQ18
        PIN.out[p] = lat_all[p];
        PIN.oe[p] = dir_all[p];
      end else begin
        PIN.out[p] = PERIPH_OUT[s - 2'h1][p]; // RQ1
        PIN.oe[p] = PERIPH_OE[s - 2'h1][p];
      end
    end
    if (debug_mode) begin // RQ15
      PIN.out[32 + `GJPM_PORT_B_TDI] = 1'b0; // RQ16
      PIN.oe[32 + `GJPM_PORT_B_TDI] = 1'b0; // RQ16
      PIN.out[32 + `GJPM_PORT_B_TMS] = 1'b0; // RQ16
      PIN.oe[32 + `GJPM_PORT_B_TMS] = 1'b0; // RQ16
      PIN.out[32 + `GJPM_PORT_B_TCK] = 1'b0; // RQ16
      PIN.oe[32 + `GJPM_PORT_B_TCK] = 1'b0; // RQ16
      PIN.out[32 + `GJPM_PORT_B_TDO] = TEST_DATA_OUT; // RQ16
      PIN.oe[32 + `GJPM_PORT_B_TDO] = 1'b1; // RQ16
    end
  end

  assign PERIPH_IN = sync2;
  assign TEST_PINS_IN = {sync2[32 + `GJPM_PORT_B_TCK], sync2[32 + `GJPM_PORT_B_TMS],
                         sync2[32 + `GJPM_PORT_B_TDO], sync2[32 + `GJPM_PORT_B_TDI]};
  assign PULLUP_ENABLE = ~{pud_b, pud_a}; // RQ8
  assign INPUT_QUALIFIER_SELECT = {q_qb[1][15:0], q_qa_hi[1][15:0], q_qa_lo[1][15:0]}; // RQ13
  assign QUALIFIER_CONTROL_A = ctrl_a;
  assign QUALIFIER_CONTROL_B = ctrl_b;
  assign ANALOG_OUT = lat_ai;
  assign ANALOG_OE = dir_ai;
  assign ANALOG_PIN_FUNCTION_SELECT = q_fsel_ai[1][15:0];
  assign EXTERNAL_INTERRUPT_ONE = sync2[xsel1[4:0]]; // RQ11
  assign EXTERNAL_INTERRUPT_TWO = sync2[xsel2[4:0]]; // RQ11
  assign EXTERNAL_INTERRUPT_THREE = sync2[xsel3[4:0]]; // RQ11
  assign LOW_POWER_STATE_WAKE = wake & sync2[31:0]; // RQ12

  // Read multiplexer; data registers read the synchronised pin levels.
  always_comb begin
    unique case (BUS.addr & 16'hfffe)
      `GJPM_PORT_A_CONTROL: rd_mux = ctrl_a;
      `GJPM_PORT_A_QUALIFIER_SELECT_LOW: rd_mux = qsel_a_lo;
      `GJPM_PORT_A_QUALIFIER_SELECT_HIGH: rd_mux = qsel_a_hi;
      `GJPM_PORT_A_FUNCTION_SELECT_LOW: rd_mux = fsel_a_lo;
      `GJPM_PORT_A_FUNCTION_SELECT_HIGH: rd_mux = fsel_a_hi;
      `GJPM_PORT_A_DIRECTION: rd_mux = dir_a;
      `GJPM_PORT_A_PULLUP_DISABLE: rd_mux = pud_a;
      `GJPM_PORT_B_CONTROL: rd_mux = ctrl_b;
      `GJPM_PORT_B_QUALIFIER_SELECT: rd_mux = qsel_b;
      `GJPM_PORT_B_FUNCTION_SELECT: rd_mux = fsel_b;
      `GJPM_PORT_B_DIRECTION: rd_mux = {19'h0, dir_b};
      `GJPM_PORT_B_PULLUP_DISABLE: rd_mux = {19'h0, pud_b};
      `GJPM_ANALOG_GROUP_FUNCTION_SELECT: rd_mux = fsel_ai;
      `GJPM_ANALOG_GROUP_DIRECTION: rd_mux = {16'h0, dir_ai};
      `GJPM_PORT_A_VALUE: rd_mux = sync2[31:0];
      `GJPM_PORT_B_VALUE: rd_mux = {19'h0, sync2[44:32]}; // RQ4
      `GJPM_ANALOG_GROUP_VALUE: rd_mux = {16'h0, ai_sync2}; // RQ4
      `GJPM_EXT_IRQ_ONE_PIN_SELECT: rd_mux = BUS.addr[0] ? {16'h0, xsel2} : {16'h0, xsel1};
      `GJPM_EXT_IRQ_THREE_PIN_SELECT: rd_mux = BUS.addr[0] ? 32'h0 : {16'h0, xsel3};
      `GJPM_WAKE_PIN_SELECT: rd_mux = wake;
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RDATA <= 32'h0;
    end else if (BUS.rd) begin
      if (!BUS.wide && BUS.addr[0] && (BUS.addr & 16'hfff0) != 16'h6fe0) RDATA <= {16'h0, rd_mux[31:16]}; // RQ3
      else RDATA <= rd_mux;
    end
  end

  a_prot_block: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ21
    (BUS.wr && !PROTECTED_WRITE_ENABLE && BUS.addr == `GJPM_PORT_A_DIRECTION) |=> $stable(dir_a))
    else $error("protected register changed while closed");
  a_set: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ20
    (BUS.wr && BUS.wide && BUS.addr == `GJPM_PORT_A_BIT_SET) |=> ((lat_a & $past(BUS.wdata)) == $past(BUS.wdata)))
    else $error("set did not set latch bits");
  a_clr: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ20
    (BUS.wr && BUS.wide && BUS.addr == `GJPM_PORT_A_BIT_CLEAR) |=> ((lat_a & $past(BUS.wdata)) == 32'h0))
    else $error("clear did not clear latch bits");
  a_tog: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ20
    (BUS.wr && BUS.wide && BUS.addr == `GJPM_PORT_A_BIT_INVERT) |=> (lat_a == ($past(lat_a) ^ $past(BUS.wdata))))
    else $error("toggle did not invert latch bits");
  a_delay: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ13
    ##2 (q_fsel_a_lo[1] == $past(fsel_a_lo, 2)))
    else $error("function select not delayed two cycles");
  a_gpio: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ18
    (fsel_all[1:0] == 2'h0) |-> (PIN.out[0] == lat_a[0] && PIN.oe[0] == dir_a[0]))
    else $error("pin zero not on latch in gpio mode");
  a_dbg: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ15
    debug_mode |-> (PIN.oe[32 + `GJPM_PORT_B_TCK] == 1'b0 && PIN.oe[32 + `GJPM_PORT_B_TDO] == 1'b1))
    else $error("test pins not given to debug port");
  a_half: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // RQ3
    (BUS.wr && !BUS.wide && !BUS.addr[0] && BUS.addr == `GJPM_PORT_A_VALUE) |=> (lat_a[31:16] == $past(lat_a[31:16])))
    else $error("half write touched upper half");
endmodule // gjpm_pin_mux
`default_nettype wire

// file: sim/gjpm_board.sv
// Board and peripheral model that faces the pin mux.
`timescale 1ns/100ps
`default_nettype none
module gjpm_board
  import gjpm_pkg::*;
(
  // Pin side.
  input  wire gjpm_pins_s  pin,
  input  wire logic [44:0] pullup_enable,
  input  wire logic [15:0] analog_out,
  output logic [44:0]      pin_in,
  output logic [15:0]      analog_in,
  // Peripheral side.
  output logic [44:0]      periph_out [3],
  output logic [44:0]      periph_oe [3]
);
  // Undriven pins go to the pull-up or away from the last driven level.
  always_comb begin
    for (int i = 0; i < 45; i++) begin
      pin_in[i] = pin.oe[i] ? pin.out[i] : (pullup_enable[i] | ~pin.out[i]);
    end
  end
  assign analog_in = analog_out;
  // Each peripheral choice shows its own fixed pattern.
  assign periph_out[0] = 45'h0aaaaaaaaaaa;
  assign periph_out[1] = 45'h155555555555;
  assign periph_out[2] = 45'h0cccc3333ccc;
  assign periph_oe[0]  = 45'h1fffffffffff;
  assign periph_oe[1]  = 45'h0f0f0f0f0f0f;
  assign periph_oe[2]  = 45'h10f00ff00ff0;
endmodule // gjpm_board
`default_nettype wire

// file: sim/gjpm_pin_mux_bench.sv
// Self-checking bench for the pin mux.
`timescale 1ns/100ps
`default_nettype none
`include "gjpm_regs.svh"
module gjpm_pin_mux_bench
  import gjpm_pkg::*;
;
  logic        core_clk, sys_rst, pwe, test_reset, tdo, x1, x2, x3;
  gjpm_bus_s   bus;
  gjpm_pins_s  pin;
  logic [31:0] rdata, wake, v;
  logic [44:0] po [3];
  logic [44:0] poe [3];
  logic [44:0] pin_in, pull;
  logic [15:0] ain, aout, aoe;
  logic [3:0]  tpi;
  logic [44:0] pin_sync;
  logic [47:0] iqs;
  logic [31:0] qca, qcb;
  logic [15:0] apfs;
  int          error_cnt, check_count;

  gjpm_pin_mux dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .BUS(bus), .PROTECTED_WRITE_ENABLE(pwe),
    .RDATA(rdata), .PERIPH_OUT(po), .PERIPH_OE(poe), .PERIPH_IN(pin_sync), .PIN_IN(pin_in), .PIN(pin),
    .PULLUP_ENABLE(pull), .INPUT_QUALIFIER_SELECT(iqs), .QUALIFIER_CONTROL_A(qca), .QUALIFIER_CONTROL_B(qcb),
    .ANALOG_IN(ain), .ANALOG_OUT(aout), .ANALOG_OE(aoe), .ANALOG_PIN_FUNCTION_SELECT(apfs),
    .TEST_RESET(test_reset), .TEST_DATA_OUT(tdo), .TEST_PINS_IN(tpi),
    .EXTERNAL_INTERRUPT_ONE(x1), .EXTERNAL_INTERRUPT_TWO(x2), .EXTERNAL_INTERRUPT_THREE(x3),
    .LOW_POWER_STATE_WAKE(wake));

  gjpm_board board (.pin(pin), .pullup_enable(pull), .analog_out(aout), .pin_in(pin_in),
    .analog_in(ain), .periph_out(po), .periph_oe(poe));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(negedge core_clk);
    bus.addr = a;
    bus.wdata = d;
    bus.wide = w;
    bus.wr = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    bus.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic w, output logic [31:0] d);
    @(negedge core_clk);
    bus.addr = a;
    bus.wide = w;
    bus.rd = 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    bus.rd = 1'b0;
    d = rdata;
  endtask

  task automatic wait_sync;
    repeat (5) @(negedge core_clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1; pwe = 1'b0; test_reset = 1'b0; tdo = 1'b0; bus = '0;
    error_cnt = 0; check_count = 0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(`GJPM_PORT_A_DIRECTION, 1'b1, v); chk(v, 0);
    chk(pin.oe, 0);
    chk(pull, 45'h1fffffffffff);
    $display("test reset values done");
    wr(`GJPM_PORT_A_DIRECTION, 32'hffffffff);
    rd(`GJPM_PORT_A_DIRECTION, 1'b1, v); chk(v, 0);
    pwe = 1'b1;
    wr(`GJPM_PORT_A_DIRECTION, 32'hffffffff);
    wr(`GJPM_PORT_A_DIRECTION + 16'h1, 32'h00001234, 1'b0);
    rd(`GJPM_PORT_A_DIRECTION, 1'b1, v); chk(v, 32'h1234ffff);
    rd(`GJPM_PORT_A_DIRECTION + 16'h1, 1'b0, v); chk(v[15:0], 16'h1234);
    wr(`GJPM_PORT_A_DIRECTION + 16'h1, 32'h0000ffff, 1'b0);
    rd(16'h6fa0, 1'b1, v); chk(v, 0);
    pwe = 1'b0;
    wr(`GJPM_PORT_A_VALUE, 32'h000000f0); chk(pin.out[31:0], 32'h000000f0);
    $display("test protection and widths done");
    wr(`GJPM_PORT_A_BIT_SET, 32'h00000f00); chk(pin.out[31:0], 32'h00000ff0);
    wr(`GJPM_PORT_A_BIT_CLEAR, 32'h00000030); chk(pin.out[31:0], 32'h00000fc0);
    wr(`GJPM_PORT_A_BIT_INVERT, 32'h80000101); chk(pin.out[31:0], 32'h80000ec1);
    chk(pin.oe[31:0], 32'hffffffff);
    pwe = 1'b1;
    wr(`GJPM_ANALOG_GROUP_DIRECTION, 32'h0000ffff); chk(aoe, 16'hffff);
    wr(`GJPM_ANALOG_GROUP_BIT_SET, 32'h000000a5);
    wr(`GJPM_ANALOG_GROUP_BIT_INVERT, 32'h000000ff); chk(aout, 16'h005a);
    wr(`GJPM_PORT_B_DIRECTION, 32'h00001fff);
    wr(`GJPM_PORT_B_VALUE, 32'h00001555);
    wr(`GJPM_PORT_B_BIT_CLEAR, 32'h00000001); chk(pin.out[44:32], 13'h1554);
    wr(`GJPM_PORT_A_PULLUP_DISABLE, 32'h00000001); chk(pull[0], 1'b0);
    $display("test latch operations done");
    for (int k = 1; k < 4; k++) begin
      wr(`GJPM_PORT_A_FUNCTION_SELECT_LOW, {16{k[1:0]}});
      @(negedge core_clk);
      chk(pin.out[15:0], (k == 1) ? 16'h0ec1 : po[k - 2][15:0]);
      @(negedge core_clk);
      chk(pin.out[15:0], po[k - 1][15:0]);
      chk(pin.oe[15:0], poe[k - 1][15:0]);
    end
    wr(`GJPM_PORT_A_FUNCTION_SELECT_HIGH, 32'haaaaaaaa);
    wr(`GJPM_PORT_B_FUNCTION_SELECT, 32'h0000003f);
    repeat (2) @(negedge core_clk);
    chk(pin.out[31:16], po[1][31:16]);
    chk(pin.out[34:32], po[2][34:32]);
    wr(`GJPM_PORT_A_FUNCTION_SELECT_LOW, 32'h0);
    wr(`GJPM_PORT_A_FUNCTION_SELECT_HIGH, 32'h0);
    wr(`GJPM_PORT_B_FUNCTION_SELECT, 32'h0);
    repeat (2) @(negedge core_clk);
    chk(pin.out[34:0], {3'h4, 32'h80000ec1});
    $display("test function select done");
    wr(`GJPM_EXT_IRQ_ONE_PIN_SELECT, 32'h6, 1'b0);
    wr(`GJPM_EXT_IRQ_TWO_PIN_SELECT, 32'h1f, 1'b0);
    wr(`GJPM_EXT_IRQ_THREE_PIN_SELECT, 32'h4, 1'b0);
    wait_sync();
    chk({x1, x2, x3}, 3'b110);
    wr(`GJPM_PORT_A_BIT_INVERT, 32'h80000040);
    pwe = 1'b0;
    wr(`GJPM_EXT_IRQ_ONE_PIN_SELECT, 32'h7, 1'b0);
    pwe = 1'b1;
    wr(`GJPM_WAKE_PIN_SELECT, 32'hffff00ff);
    wait_sync();
    chk({x1, x2, x3}, 3'b000);
    chk(wake, 32'h00000081);
    $display("test interrupt and wake selects done");
    wr(`GJPM_PORT_A_QUALIFIER_SELECT_LOW, 32'h00001111);
    wr(`GJPM_PORT_A_QUALIFIER_SELECT_HIGH, 32'h00002222);
    wr(`GJPM_PORT_B_QUALIFIER_SELECT, 32'h00003333);
    wr(`GJPM_ANALOG_GROUP_FUNCTION_SELECT, 32'h0000000c);
    chk(apfs, 16'h0000);
    wr(`GJPM_PORT_A_CONTROL, 32'h00000055);
    wr(`GJPM_PORT_B_CONTROL, 32'h000000aa);
    chk(iqs, 48'h333322221111);
    chk(apfs, 16'h000c);
    chk({qca, qcb}, 64'h00000055000000aa);
    chk(pin_sync, pin_in);
    rd(`GJPM_ANALOG_GROUP_VALUE, 1'b1, v); chk(v, 32'h0000005a);
    $display("test qualifier and control done");
    tdo = 1'b1;
    test_reset = 1'b1;
    wait_sync();
    chk(pin.oe[38:35], 4'b0100);
    chk(pin.out[37], 1'b1);
    chk(tpi, 4'b1111);
    tdo = 1'b0;
    wait_sync();
    chk({pin.out[37], tpi}, 5'b01101);
    test_reset = 1'b0;
    wait_sync();
    chk({pin.oe[38:35], pin.out[38:35]}, 8'hfa);
    $display("test debug sharing done");
    complete_run();
  end
endmodule // gjpm_pin_mux_bench
`default_nettype wire
